// ==== shared/pifl_defines.vh ====
`ifndef PIFL_DEFINES_VH
`define PIFL_DEFINES_VH
// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define PIFL_ADDR_FLAG 4'h0
`define PIFL_ADDR_MASK 4'h4
`define PIFL_ADDR_CTRL 4'h8
// ---------------------------------------------
// flag bit positions
// ---------------------------------------------
`define PIFL_BIT_ECCP 0
`define PIFL_BIT_T2OV 1
`define PIFL_BIT_VDET 2
`define PIFL_BIT_BCOL 3
// ---------------------------------------------
// capture/compare mode field
// ---------------------------------------------
`define PIFL_MODE_CAPTURE 2'h0
`define PIFL_MODE_COMPARE 2'h1
`define PIFL_MODE_PWM 2'h2
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define PIFL_RST_FLAG 4'h0
`define PIFL_RST_MASK 4'h0
`define PIFL_RST_MODE 2'h0
`endif

// ==== src/pifl_sticky_bit.v ====
`timescale 1ns/1ps
`include "pifl_defines.vh"
module pifl_sticky_bit (
  sys_clk,
  rst_n,
  set_evt,
  sw_wr,
  sw_wdata,
  sw_rd_clr,
  flag
);
  input wire sys_clk;
  input wire rst_n;
  input wire set_evt;
  input wire sw_wr;
  input wire sw_wdata;
  input wire sw_rd_clr;
  output wire flag;
  reg flag_reg;
  reg flag_next;
  // ---------------------------------------------
  // set wins over any clear
  // ---------------------------------------------
  always @* begin
    flag_next = flag_reg;
    if (sw_rd_clr)
      flag_next = 1'b0;
    if (sw_wr)
      flag_next = sw_wdata;
    if (set_evt)
      flag_next = 1'b1;
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end
  assign flag = flag_reg;
endmodule // pifl_sticky_bit

// ==== src/pifl_flags.v ====
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "pifl_defines.vh"
// Function
// - collision sets flag, software writes zero
// - voltage trip sets flag until cleared
// - timer overflow sets flag until cleared
// - timer flag reads zero unless an overflow or a software write of one set it
// - capture/compare flag only in large variant
module pifl_flags #(
  parameter LARGE_VARIANT = 1
) (
  sys_clk,
  rst_n,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  bus_collision_evt,
  voltage_trip_evt,
  second_timer_count_ovf,
  first_timer_capture_evt,
  first_timer_compare_evt,
  irq,
  bus_collision_flag,
  voltage_detect_flag,
  second_timer_overflow_flag,
  enhanced_capture_compare_flag
);
  input wire sys_clk;
  input wire rst_n;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [3:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  input wire bus_collision_evt;
  input wire voltage_trip_evt;
  input wire second_timer_count_ovf;
  input wire first_timer_capture_evt;
  input wire first_timer_compare_evt;
  output wire irq;
  output wire bus_collision_flag;
  output wire voltage_detect_flag;
  output wire second_timer_overflow_flag;
  output wire enhanced_capture_compare_flag;

  // ---------------------------------------------
  // sizes
  // ---------------------------------------------
  localparam NUM_FLAGS = 4;
  localparam MODE_W = 2;
  localparam DATA_W = 32;
  localparam PAD_FLAG = DATA_W - NUM_FLAGS;
  localparam PAD_MODE = DATA_W - MODE_W;

  // ---------------------------------------------
  // address match, shared by the three register select decodes
  // ---------------------------------------------
  function addr_hit(input [3:0] adr, input [3:0] ofs);
    addr_hit = (adr == ofs);
  endfunction

  // ---------------------------------------------
  // capture/compare event picked by mode
  // ---------------------------------------------
  function cc_pick(input [MODE_W-1:0] mode, input cap_evt, input cmp_evt);
    case (mode)
      `PIFL_MODE_CAPTURE: cc_pick = cap_evt;
      `PIFL_MODE_COMPARE: cc_pick = cmp_evt;
      default: cc_pick = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------
  // internal signals
  // ---------------------------------------------
  wire req;
  wire rd_req;
  wire wr_req;
  wire sel_flag;
  wire sel_mask;
  wire sel_ctrl;
  wire rd_flag;
  wire wr_flag;
  wire wr_mask;
  wire wr_ctrl;
  wire cc_evt;
  wire [NUM_FLAGS-1:0] impl_mask;
  wire [NUM_FLAGS-1:0] evts;
  wire [NUM_FLAGS-1:0] wr_bits;
  wire [NUM_FLAGS-1:0] flags;
  reg [NUM_FLAGS-1:0] mask_reg;
  reg [NUM_FLAGS-1:0] mask_next;
  reg [MODE_W-1:0] mode_reg;
  reg [MODE_W-1:0] mode_next;
  reg [DATA_W-1:0] rdata_next;
  reg ack_next;

  // ---------------------------------------------
  // bus decode
  // ---------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_req = req & ~wb_we_i;
  assign wr_req = req & wb_we_i & wb_sel_i[0];
  assign sel_flag = addr_hit(wb_adr_i, `PIFL_ADDR_FLAG);
  assign sel_mask = addr_hit(wb_adr_i, `PIFL_ADDR_MASK);
  assign sel_ctrl = addr_hit(wb_adr_i, `PIFL_ADDR_CTRL);
  assign rd_flag = rd_req & sel_flag;
  assign wr_flag = wr_req & sel_flag;
  assign wr_mask = wr_req & sel_mask;
  assign wr_ctrl = wr_req & sel_ctrl;

  // ---------------------------------------------
  // implemented bits
  // ---------------------------------------------
  assign impl_mask = LARGE_VARIANT ? 4'hf : 4'he;
  assign wr_bits = wb_dat_i[NUM_FLAGS-1:0] & impl_mask;

  // ---------------------------------------------
  // event sources
  // ---------------------------------------------
  assign cc_evt = cc_pick(mode_reg, first_timer_capture_evt, first_timer_compare_evt);
  assign evts[`PIFL_BIT_BCOL] = bus_collision_evt;
  assign evts[`PIFL_BIT_VDET] = voltage_trip_evt;
  assign evts[`PIFL_BIT_T2OV] = second_timer_count_ovf;
  assign evts[`PIFL_BIT_ECCP] = cc_evt & impl_mask[`PIFL_BIT_ECCP];

  // ---------------------------------------------
  // sticky flags, set wins over clear
  // ---------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_FLAGS; i = i + 1) begin : g_flag
      pifl_sticky_bit u_bit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set_evt(evts[i]),
        .sw_wr(wr_flag & impl_mask[i]),
        .sw_wdata(wr_bits[i]),
        .sw_rd_clr(rd_flag),
        .flag(flags[i])
      );
    end
  endgenerate

  // ---------------------------------------------
  // mask register
  // ---------------------------------------------
  always @* begin
    mask_next = mask_reg;
    if (wr_mask)
      mask_next = wr_bits;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mask_reg <= `PIFL_RST_MASK;
    else
      mask_reg <= mask_next;
  end

  // ---------------------------------------------
  // capture/compare mode register
  // ---------------------------------------------
  always @* begin
    mode_next = mode_reg;
    if (wr_ctrl)
      mode_next = wb_dat_i[MODE_W-1:0];
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mode_reg <= `PIFL_RST_MODE;
    else
      mode_reg <= mode_next;
  end

  // ---------------------------------------------
  // read data
  // ---------------------------------------------
  always @* begin
    rdata_next = wb_dat_o;
    if (rd_req) begin
      case (wb_adr_i)
        `PIFL_ADDR_FLAG: rdata_next = {{PAD_FLAG{1'b0}}, flags};
        `PIFL_ADDR_MASK: rdata_next = {{PAD_FLAG{1'b0}}, mask_reg};
        `PIFL_ADDR_CTRL: rdata_next = {{PAD_MODE{1'b0}}, mode_reg};
        default: rdata_next = {DATA_W{1'b0}};
      endcase
    end
  end

  // ---------------------------------------------
  // acknowledge, one cycle after the request
  // ---------------------------------------------
  always @* begin
    ack_next = req;
  end

  // ---------------------------------------------
  // bus output flops
  // ---------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= {DATA_W{1'b0}};
    end else begin
      wb_ack_o <= ack_next;
      wb_dat_o <= rdata_next;
    end
  end

  // ---------------------------------------------
  // interrupt output
  // ---------------------------------------------
  assign irq = |(flags & mask_reg);

  // ---------------------------------------------
  // flag outputs
  // ---------------------------------------------
  assign bus_collision_flag = flags[`PIFL_BIT_BCOL];
  assign voltage_detect_flag = flags[`PIFL_BIT_VDET];
  assign second_timer_overflow_flag = flags[`PIFL_BIT_T2OV];
  assign enhanced_capture_compare_flag = flags[`PIFL_BIT_ECCP];
endmodule // pifl_flags

// ==== testbench/pifl_flags_chk.sv ====
`timescale 1ns/1ps
module pifl_flags_chk (
  input logic sys_clk,
  input logic rst_n,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic wb_ack_o,
  input logic irq,
  input logic bus_collision_evt,
  input logic voltage_trip_evt,
  input logic second_timer_count_ovf,
  input logic first_timer_capture_evt,
  input logic first_timer_compare_evt,
  input logic bus_collision_flag,
  input logic voltage_detect_flag,
  input logic second_timer_overflow_flag,
  input logic enhanced_capture_compare_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_bcol_set: assert property (bus_collision_evt |=> bus_collision_flag) else $error("bcol");
  chk_vdet_set: assert property (voltage_trip_evt |=> voltage_detect_flag) else $error("vdet");
  chk_vdet_hold: assert property (voltage_detect_flag && !wb_stb_i |=> voltage_detect_flag) else $error("hold");
  chk_tovf_set: assert property (second_timer_count_ovf |=> second_timer_overflow_flag) else $error("tovf");
  chk_tovf_cause: assert property ($rose(second_timer_overflow_flag)
    |-> $past(second_timer_count_ovf | wb_we_i)) else $error("tcause");
  chk_ecc_cause: assert property ($rose(enhanced_capture_compare_flag)
    |-> $past(first_timer_capture_evt | first_timer_compare_evt | wb_we_i)) else $error("ecc");
  cover property (irq);
  cover property (wb_ack_o && !wb_we_i);
  cover property (first_timer_compare_evt);
endmodule // pifl_flags_chk

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic sys_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o, exp_q[$];
  logic [4:0] evt = '0;
  logic [2:0] v;
  logic wb_ack_o, irq, bus_collision_flag, voltage_detect_flag;
  logic second_timer_overflow_flag, enhanced_capture_compare_flag;
  logic [3:0] mk;
  logic [31:0] exp_w;
  wire [3:0] flag_out = {bus_collision_flag, voltage_detect_flag, second_timer_overflow_flag,
    enhanced_capture_compare_flag};
  wire bus_collision_evt, voltage_trip_evt, second_timer_count_ovf, first_timer_capture_evt, first_timer_compare_evt;
  int fail_count = 0, cmp_count = 0, cyc_n = 0, m;
  assign {bus_collision_evt, voltage_trip_evt, second_timer_count_ovf, first_timer_capture_evt,
    first_timer_compare_evt} = evt;
  pifl_flags dut_u (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      fail_count++;
      end_of_test;
    end else if (wb_ack_o && !wb_we_i) begin
      exp_w = exp_q.pop_front();
      `CHK(wb_dat_o, exp_w)
    end
  end
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, e);
    if (!we) exp_q.push_back(e);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    do @(posedge sys_clk); while (!wb_ack_o);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= '0;
    @(posedge sys_clk);
  endtask
  task automatic ev(input logic [4:0] x);
    evt <= x;
    @(posedge sys_clk);
    evt <= '0;
    @(posedge sys_clk);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(37868));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    wb(0, 4'h0, '0, '0);
    wb(1, 4'h4, 32'hf, '0);
    repeat (4) begin
      v = $urandom;
      mk = 4'($urandom);
      wb(1, 4'h4, {28'h0, mk}, '0);
      wb(0, 4'h4, '0, {28'h0, mk});
      ev({v, 2'h0});
      `CHK(irq, |({v, 1'h0} & mk))
      `CHK(flag_out, {v, 1'h0})
      wb(0, 4'h0, '0, {v, 1'h0});
    end
    wb(0, 4'h0, '0, '0);
    ev(5'h1c);
    wb(1, 4'h0, '0, '0);
    wb(0, 4'h0, '0, '0);
    for (m = 0; m < 3; m++) begin
      wb(1, 4'h8, m, '0);
      ev(5'h03);
      `CHK(flag_out[0], m < 2)
      wb(0, 4'h0, '0, m < 2);
    end
    wb(0, 4'hc, '0, '0);
    end_of_test;
  end
endmodule // tb_top
bind pifl_flags pifl_flags_chk chk_u (.*);
